// >>> design/pec_regs.sv
// Notes on behaviour
// [R1] Parallel-detection fault sets expansion bit 4 and holds it until read.
// [R2] Expansion bit 3 shows partner next-page ability; resets to zero.
// [R3] Expansion bit 2 is fixed local next-page ability, zero.
// [R4] Expansion bit 1 latches a new page; reading address 6 clears it.
// [R5] Expansion bit 0 shows partner auto-negotiation ability.
// [R6] Config bit 15 bypasses block coder and decoder; reset zero.
// [R7] Config bit 14 bypasses scrambler and descrambler; reset zero.
// [R8] Config bit 13 bypasses alignment, decoding, encoding and scrambling.
// [R9] Config bit 12 forces signal detect active.
// [R10] Config bit 10 selects copper (one, reset) or fibre mode.
// [R11] Config bit 7 forces good 100 Mbit/s link status; reset zero.
// [R12] Config bit 4 enables automatic reduced power-down; reset one.
// [R13] Writing one to bit 3 resets state machines; bit self-clears.
// [R14] Config bit 2 controls management preamble suppression; reset one.
// [R15] Writing one to bit 1 enters sleep, all but clocks powered down.
// [R16] Clearing sleep keeps prior configuration and resets state machines.
// [R17] Management writes zero to reserved config bit 0.
// [R18] Management writes zero to expansion bits 15..5, ignores reads.
// [R19] Reading the expansion register also clears the fault flag.
`timescale 1ns/1ps
`default_nettype none

module pec_regs
    import pec_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire pec_mgmt_req_type  mgmt_req,
    output var  logic [15:0]       rd_data,
    output var  logic              rd_valid,
    input  wire pec_an_status_type an_status,
    input  wire logic              line_signal_detect,
    input  wire logic              raw_link_good_100,
    output var  pec_phy_ctrl_type  phy_ctrl
);

    // ==========================================================
    // Declarations
    // ==========================================================
    logic [15:0]         cfg_reg;
    logic [15:0]         cfg_next;
    logic [15:0]         rd_data_reg;
    logic [15:0]         rd_data_next;
    logic                rd_valid_reg;
    logic                partner_np_reg;
    logic                partner_an_reg;
    logic                sd_meta_reg;
    logic                sd_sync_reg;
    pec_power_state_type state_reg;
    pec_power_state_type state_next;
    pec_phy_ctrl_type    ctrl_reg;
    pec_phy_ctrl_type    ctrl_next;

    logic                hit_expansion;
    logic                hit_config;
    logic                rd_expansion;
    logic                wr_config;
    logic                fault_flag;
    logic                page_flag;
    logic [15:0]         expansion_value;
    logic [15:0]         config_value;
    logic                sw_reset_request;
    logic                wake_reset_request;
    logic                timer_start;
    logic                timer_busy;
    logic                timer_done;
    logic                cfg_sleep;
    logic                is_sleep;
    logic                is_wake;
    logic                asleep;
    logic                bypass_align;

    // ==========================================================
    // Address decode
    // ==========================================================
    assign hit_expansion = (mgmt_req.addr == PEC_ADDR_EXPANSION);
    assign hit_config    = (mgmt_req.addr == PEC_ADDR_CONFIG);
    assign rd_expansion  = mgmt_req.rd_en && hit_expansion;
    assign wr_config     = mgmt_req.wr_en && hit_config;

    // ==========================================================
    // Latched expansion flags
    // ==========================================================
    pec_sticky_flag u_fault_flag (
        .clock       (clock),
        .rst_n       (rst_n),
        .set_pulse   (an_status.fault_event),             // [R1]
        .clear_pulse (rd_expansion),                      // [R19]
        .flag        (fault_flag)
    );

    pec_sticky_flag u_page_flag (
        .clock       (clock),
        .rst_n       (rst_n),
        .set_pulse   (an_status.page_event),              // [R4]
        .clear_pulse (rd_expansion),                      // [R4]
        .flag        (page_flag)
    );

    // Partner abilities are levels from negotiation logic
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            partner_np_reg <= 1'b0;
            partner_an_reg <= 1'b0;
        end else begin
            partner_np_reg <= an_status.partner_next_page_capable; // [R2]
            partner_an_reg <= an_status.partner_negotiation_capable; // [R5]
        end
    end

    // ==========================================================
    // Read data assembly
    // ==========================================================
    // Reserved bits 15..5 read as zero; writes to them have no effect
    always_comb begin
        expansion_value = PEC_DATA_ZERO;                  // [R18]
        expansion_value[PEC_EXP_FAULT_BIT]      = fault_flag;      // [R1]
        expansion_value[PEC_EXP_PARTNER_NP_BIT] = partner_np_reg;  // [R2]
        expansion_value[PEC_EXP_LOCAL_NP_BIT]   =
            PEC_LOCAL_NP_CAPABLE;                         // [R3]
        expansion_value[PEC_EXP_PAGE_RX_BIT]    = page_flag;       // [R4]
        expansion_value[PEC_EXP_PARTNER_AN_BIT] = partner_an_reg;  // [R5]
    end

    // Reset bit reads back one while the reset pulse runs
    always_comb begin
        config_value = cfg_reg & PEC_CFG_WRITE_MASK;
        config_value[PEC_CFG_SM_RESET_BIT] = timer_busy;  // [R13]
    end

    // Flags are sampled before the read clears them
    assign rd_data_next = !mgmt_req.rd_en ? rd_data_reg     :
                          hit_expansion   ? expansion_value :
                          hit_config      ? config_value    :
                                            PEC_DATA_ZERO;

    // ==========================================================
    // Configuration register
    // ==========================================================
    // Reserved bit 0 is stored as written; software keeps it zero
    always_comb begin
        cfg_next = cfg_reg;
        if (wr_config) begin
            cfg_next = (mgmt_req.wr_data & PEC_CFG_WRITE_MASK); // [R17]
        end
        // Reset bit is never held; the timer reports its progress
        cfg_next[PEC_CFG_SM_RESET_BIT] = 1'b0;            // [R13]
    end

    assign sw_reset_request = wr_config &&
        mgmt_req.wr_data[PEC_CFG_SM_RESET_BIT];           // [R13]

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cfg_reg      <= PEC_CFG_RESET_VALUE;
            rd_data_reg  <= PEC_DATA_ZERO;
            rd_valid_reg <= 1'b0;
        end else begin
            cfg_reg      <= cfg_next;
            rd_data_reg  <= rd_data_next;
            rd_valid_reg <= mgmt_req.rd_en;
        end
    end

    // ==========================================================
    // Sleep sequencing
    // ==========================================================
    assign cfg_sleep = cfg_reg[PEC_CFG_SLEEP_BIT];

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PEC_ST_RUN: begin
                if (cfg_sleep) begin
                    state_next = PEC_ST_SLEEP;            // [R15]
                end
            end
            PEC_ST_SLEEP: begin
                if (!cfg_sleep) begin
                    state_next = PEC_ST_WAKE;             // [R16]
                end
            end
            PEC_ST_WAKE: begin
                if (timer_done) begin
                    state_next = PEC_ST_RUN;
                end
            end
            default: begin
                state_next = PEC_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg <= PEC_ST_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    assign is_sleep = (state_reg == PEC_ST_SLEEP);
    assign is_wake  = (state_reg == PEC_ST_WAKE);
    // Stored bit counts at once, so no cycle shows power-down with a link
    assign asleep   = cfg_sleep || is_sleep;              // [R15]

    // Configuration is untouched by sleep, so waking restores it
    assign wake_reset_request = is_sleep && !cfg_sleep;   // [R16]
    // A request while a pulse runs merges into that pulse
    assign timer_start = sw_reset_request || wake_reset_request;

    pec_reset_timer u_reset_timer (
        .clock (clock),
        .rst_n (rst_n),
        .start (timer_start),                             // [R13]
        .busy  (timer_busy),
        .done  (timer_done)
    );

    // ==========================================================
    // Line signal detect synchroniser
    // ==========================================================
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sd_meta_reg <= 1'b0;
            sd_sync_reg <= 1'b0;
        end else begin
            sd_meta_reg <= line_signal_detect;
            sd_sync_reg <= sd_meta_reg;
        end
    end

    // ==========================================================
    // Control outputs
    // ==========================================================
    assign bypass_align = cfg_reg[PEC_CFG_BYPASS_ALIGN_BIT];

    // Alignment bypass also skips coding and scrambling paths
    always_comb begin
        ctrl_next.bypass_symbol_alignment = bypass_align;  // [R8]
        ctrl_next.bypass_block_coding =
            cfg_reg[PEC_CFG_BYPASS_CODING_BIT] || bypass_align; // [R6] [R8]
        ctrl_next.bypass_scrambling =
            cfg_reg[PEC_CFG_BYPASS_SCRAM_BIT] || bypass_align;  // [R7] [R8]
        // Powered-down receiver reports no signal and no link
        ctrl_next.signal_detect = !asleep &&
            (cfg_reg[PEC_CFG_FORCE_SD_BIT] || sd_sync_reg);     // [R9]
        ctrl_next.mode_100base_tx = cfg_reg[PEC_CFG_TX_MODE_BIT]; // [R10]
        ctrl_next.link_good_100 = !asleep &&
            (cfg_reg[PEC_CFG_FORCE_LINK_BIT] || raw_link_good_100); // [R11]
        ctrl_next.auto_reduced_powerdown_enable =
            cfg_reg[PEC_CFG_AUTO_RPD_BIT];                // [R12]
        ctrl_next.state_machine_reset =
            timer_busy || asleep || is_wake;              // [R13] [R16]
        ctrl_next.mgmt_preamble_suppress =
            cfg_reg[PEC_CFG_PREAMBLE_BIT];                // [R14]
        ctrl_next.sleep_powerdown = asleep;               // [R15]
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_reg.bypass_block_coding           <= 1'b0;
            ctrl_reg.bypass_scrambling             <= 1'b0;
            ctrl_reg.bypass_symbol_alignment       <= 1'b0;
            ctrl_reg.signal_detect                 <= 1'b0;
            ctrl_reg.mode_100base_tx               <=
                PEC_CFG_RESET_VALUE[PEC_CFG_TX_MODE_BIT];
            ctrl_reg.link_good_100                 <= 1'b0;
            ctrl_reg.auto_reduced_powerdown_enable <=
                PEC_CFG_RESET_VALUE[PEC_CFG_AUTO_RPD_BIT];
            ctrl_reg.state_machine_reset           <= 1'b0;
            ctrl_reg.mgmt_preamble_suppress        <=
                PEC_CFG_RESET_VALUE[PEC_CFG_PREAMBLE_BIT];
            ctrl_reg.sleep_powerdown               <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    assign rd_data  = rd_data_reg;
    assign rd_valid = rd_valid_reg;
    assign phy_ctrl = ctrl_reg;

endmodule

`default_nettype wire

// >>> design/pec_pkg.sv
`default_nettype none

package pec_pkg;

    // ==========================================================
    // Management register addresses
    // ==========================================================
    localparam logic [4:0]  PEC_ADDR_EXPANSION = 5'h06;
    localparam logic [4:0]  PEC_ADDR_CONFIG    = 5'h10;

    // ==========================================================
    // Expansion status field positions
    // ==========================================================
    localparam int unsigned PEC_EXP_FAULT_BIT      = 4;
    localparam int unsigned PEC_EXP_PARTNER_NP_BIT = 3;
    localparam int unsigned PEC_EXP_LOCAL_NP_BIT   = 2;
    localparam int unsigned PEC_EXP_PAGE_RX_BIT    = 1;
    localparam int unsigned PEC_EXP_PARTNER_AN_BIT = 0;

    // Local side offers no next page
    localparam logic        PEC_LOCAL_NP_CAPABLE = 1'b0;

    // ==========================================================
    // Configuration field positions
    // ==========================================================
    localparam int unsigned PEC_CFG_BYPASS_CODING_BIT = 15;
    localparam int unsigned PEC_CFG_BYPASS_SCRAM_BIT  = 14;
    localparam int unsigned PEC_CFG_BYPASS_ALIGN_BIT  = 13;
    localparam int unsigned PEC_CFG_FORCE_SD_BIT      = 12;
    localparam int unsigned PEC_CFG_TX_MODE_BIT       = 10;
    localparam int unsigned PEC_CFG_FORCE_LINK_BIT    = 7;
    localparam int unsigned PEC_CFG_AUTO_RPD_BIT      = 4;
    localparam int unsigned PEC_CFG_SM_RESET_BIT      = 3;
    localparam int unsigned PEC_CFG_PREAMBLE_BIT      = 2;
    localparam int unsigned PEC_CFG_SLEEP_BIT         = 1;
    localparam int unsigned PEC_CFG_RESERVED0_BIT     = 0;

    localparam logic [15:0] PEC_CFG_RESET_VALUE = 16'h0414;
    localparam logic [15:0] PEC_CFG_WRITE_MASK  = 16'hf49f;
    localparam logic [15:0] PEC_DATA_ZERO       = 16'h0000;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int unsigned PEC_CLOCK_PERIOD_NS   = 100;
    localparam int unsigned PEC_SM_RESET_TIME_NS  = 1000;
    localparam int unsigned PEC_SM_RESET_CYCLES   =
        (PEC_SM_RESET_TIME_NS + PEC_CLOCK_PERIOD_NS - 1) /
        PEC_CLOCK_PERIOD_NS;
    localparam int unsigned PEC_SM_COUNT_WIDTH    = 8;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [2:0] {
        PEC_ST_RUN   = 3'b001,
        PEC_ST_SLEEP = 3'b010,
        PEC_ST_WAKE  = 3'b100
    } pec_power_state_type;

    typedef struct packed {
        logic        rd_en;
        logic        wr_en;
        logic [4:0]  addr;
        logic [15:0] wr_data;
    } pec_mgmt_req_type;

    typedef struct packed {
        logic fault_event;
        logic page_event;
        logic partner_next_page_capable;
        logic partner_negotiation_capable;
    } pec_an_status_type;

    typedef struct packed {
        logic bypass_block_coding;
        logic bypass_scrambling;
        logic bypass_symbol_alignment;
        logic signal_detect;
        logic mode_100base_tx;
        logic link_good_100;
        logic auto_reduced_powerdown_enable;
        logic state_machine_reset;
        logic mgmt_preamble_suppress;
        logic sleep_powerdown;
    } pec_phy_ctrl_type;

endpackage

`default_nettype wire

// >>> design/pec_sticky_flag.sv
`timescale 1ns/1ps
`default_nettype none

module pec_sticky_flag
    import pec_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic set_pulse,
    input  wire logic clear_pulse,
    output var  logic flag
);

    logic flag_reg;
    logic flag_next;

    // A set in the clearing cycle wins so no event is lost
    assign flag_next = set_pulse ? 1'b1 :
                       clear_pulse ? 1'b0 : flag_reg;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flag = flag_reg;

endmodule

`default_nettype wire

// >>> design/pec_reset_timer.sv
`timescale 1ns/1ps
`default_nettype none

module pec_reset_timer
    import pec_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic start,
    output var  logic busy,
    output var  logic done
);

    localparam logic [PEC_SM_COUNT_WIDTH-1:0] LAST_COUNT =
        PEC_SM_COUNT_WIDTH'(PEC_SM_RESET_CYCLES - 1);
    localparam logic [PEC_SM_COUNT_WIDTH-1:0] COUNT_ZERO =
        PEC_SM_COUNT_WIDTH'(0);
    localparam logic [PEC_SM_COUNT_WIDTH-1:0] COUNT_ONE =
        PEC_SM_COUNT_WIDTH'(1);

    logic                          busy_reg;
    logic                          done_reg;
    logic [PEC_SM_COUNT_WIDTH-1:0] count_reg;
    logic                          at_end;

    assign at_end = busy_reg && (count_reg == LAST_COUNT);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            busy_reg  <= 1'b0;
            done_reg  <= 1'b0;
            count_reg <= COUNT_ZERO;
        end else begin
            done_reg <= at_end;
            if (at_end) begin
                busy_reg  <= 1'b0;
                count_reg <= COUNT_ZERO;
            end else if (busy_reg) begin
                count_reg <= count_reg + COUNT_ONE;
            end else if (start) begin
                busy_reg  <= 1'b1;
                count_reg <= COUNT_ZERO;
            end
        end
    end

    assign busy = busy_reg;
    assign done = done_reg;

endmodule

`default_nettype wire

// >>> dv/pec_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none

module pec_regs_properties
    import pec_pkg::*;
(
    input wire logic              clock,
    input wire logic              rst_n,
    input wire pec_mgmt_req_type  mgmt_req,
    input wire logic [15:0]       rd_data,
    input wire logic              rd_valid,
    input wire pec_an_status_type an_status,
    input wire logic              line_signal_detect,
    input wire logic              raw_link_good_100,
    input wire pec_phy_ctrl_type  phy_ctrl
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // ==========================================================
    // Decodes
    // ==========================================================
    wire logic quiet  = !an_status.fault_event && !an_status.page_event;
    wire logic exp_rd = mgmt_req.rd_en && mgmt_req.addr == PEC_ADDR_EXPANSION;
    wire logic cfg_wr = mgmt_req.wr_en && mgmt_req.addr == PEC_ADDR_CONFIG;
    wire logic unm_rd = mgmt_req.rd_en && mgmt_req.addr != PEC_ADDR_EXPANSION
                        && mgmt_req.addr != PEC_ADDR_CONFIG;

    sequence s_quiet_read;
        exp_rd && quiet;
    endsequence

    sequence s_reset_write;
        cfg_wr && mgmt_req.wr_data[PEC_CFG_SM_RESET_BIT];
    endsequence

    // ==========================================================
    // Properties
    // ==========================================================
    a_read_answer: assert property (mgmt_req.rd_en |=> rd_valid)
        else $error("read not answered in one cycle");
    a_valid_cause: assert property (rd_valid |-> $past(mgmt_req.rd_en))
        else $error("read valid without a read");
    a_local_np: assert property (exp_rd |=> !rd_data[2])
        else $error("local next page bit set");
    a_read_clears: assert property (
        s_quiet_read ##1 quiet ##1 s_quiet_read |=>
            !rd_data[PEC_EXP_PAGE_RX_BIT] && !rd_data[PEC_EXP_FAULT_BIT])
        else $error("latched flag survived a read");
    a_mode_follow: assert property (cfg_wr |-> ##2
        phy_ctrl.mode_100base_tx == $past(mgmt_req.wr_data[10], 2))
        else $error("line mode does not follow write");
    a_coding_bypass: assert property (cfg_wr |-> ##2
        phy_ctrl.bypass_block_coding ==
        ($past(mgmt_req.wr_data[15], 2) || $past(mgmt_req.wr_data[13], 2)))
        else $error("coder bypass wrong");
    a_scram_bypass: assert property (cfg_wr |-> ##2
        phy_ctrl.bypass_scrambling ==
        ($past(mgmt_req.wr_data[14], 2) || $past(mgmt_req.wr_data[13], 2)))
        else $error("scrambler bypass wrong");
    a_rpd_follow: assert property (cfg_wr |-> ##2
        phy_ctrl.auto_reduced_powerdown_enable == $past(mgmt_req.wr_data[4], 2))
        else $error("reduced power-down enable wrong");
    a_preamble_follow: assert property (cfg_wr |-> ##2
        phy_ctrl.mgmt_preamble_suppress == $past(mgmt_req.wr_data[2], 2))
        else $error("preamble suppression wrong");
    a_reset_pulse: assert property (
        s_reset_write |-> ##2 phy_ctrl.state_machine_reset [*8])
        else $error("state machine reset pulse too short");
    a_sleep_resets: assert property (
        phy_ctrl.sleep_powerdown |-> phy_ctrl.state_machine_reset &&
        !phy_ctrl.link_good_100 && !phy_ctrl.signal_detect)
        else $error("sleep leaves circuits active");
    a_link_normal: assert property (raw_link_good_100 ##1
        (!phy_ctrl.sleep_powerdown && !phy_ctrl.state_machine_reset)
        |-> phy_ctrl.link_good_100)
        else $error("good link not reported");
    a_unmapped_zero: assert property (unm_rd |=> rd_data == PEC_DATA_ZERO)
        else $error("unmapped read not zero");
endmodule

bind pec_regs pec_regs_properties u_props (
    .clock              (clock),
    .rst_n              (rst_n),
    .mgmt_req           (mgmt_req),
    .rd_data            (rd_data),
    .rd_valid           (rd_valid),
    .an_status          (an_status),
    .line_signal_detect (line_signal_detect),
    .raw_link_good_100  (raw_link_good_100),
    .phy_ctrl           (phy_ctrl)
);

`default_nettype wire

// >>> dv/pec_mgmt_model.sv
`timescale 1ns/1ps
`default_nettype none

module pec_mgmt_model
    import pec_pkg::*;
(
    input  wire logic             clock,
    input  wire logic [15:0]      rd_data,
    input  wire logic             rd_valid,
    output var  pec_mgmt_req_type mgmt_req
);
    initial mgmt_req = '0;

    // ==========================================================
    // Station manager cycles, each request held one cycle, at most one every two cycles
    // ==========================================================
    task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
        @(negedge clock);
        mgmt_req.wr_en   = 1'b1;
        mgmt_req.addr    = a;
        mgmt_req.wr_data = (a == PEC_ADDR_CONFIG) ? (d & 16'hfffe) :
            (a == PEC_ADDR_EXPANSION) ? (d & 16'h001f) : d;
        @(negedge clock);
        mgmt_req.wr_en   = 1'b0;
    endtask

    task automatic read_reg(input logic [4:0] a, output logic [15:0] d,
                            output logic v);
        @(negedge clock);
        mgmt_req.rd_en = 1'b1;
        mgmt_req.addr  = a;
        @(negedge clock);
        mgmt_req.rd_en = 1'b0;
        v = rd_valid;
        d = rd_data;
    endtask
endmodule

`default_nettype wire

// >>> dv/test_phy_expansion_vendor_config.sv
`timescale 1ns/1ps
`default_nettype none

module test_phy_expansion_vendor_config;
    import pec_pkg::*;

    logic              clock = 1'b0;
    logic              rst_n = 1'b0;
    pec_an_status_type an_status = '0;
    logic              line_sd = 1'b0;
    logic              raw_link = 1'b0;
    pec_mgmt_req_type  mgmt_req;
    logic [15:0]       rd_data;
    logic              rd_valid;
    pec_phy_ctrl_type  phy_ctrl;
    int                bad_count = 0;
    int                n_compared = 0;

    always #50 clock = ~clock;

    pec_regs dut (
        .clock              (clock),
        .rst_n              (rst_n),
        .mgmt_req           (mgmt_req),
        .rd_data            (rd_data),
        .rd_valid           (rd_valid),
        .an_status          (an_status),
        .line_signal_detect (line_sd),
        .raw_link_good_100  (raw_link),
        .phy_ctrl           (phy_ctrl)
    );

    pec_mgmt_model mgmt (
        .clock    (clock),
        .rd_data  (rd_data),
        .rd_valid (rd_valid),
        .mgmt_req (mgmt_req)
    );

    // ==========================================================
    // Helpers
    // ==========================================================
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic        v;
        mgmt.read_reg(a, d, v);
        check({15'h0000, v}, 16'h0001);
        check(d, exp);
    endtask

    // Control struct packed msb first, ten bits
    task automatic ctl_chk(input logic [9:0] exp);
        check({6'h00, phy_ctrl}, {6'h00, exp});
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_reset_values;
        rd_chk(PEC_ADDR_CONFIG, 16'h0414);
        rd_chk(PEC_ADDR_EXPANSION, 16'h0000);
        ctl_chk(10'h02a);
    endtask

    task automatic t_config_bits;
        logic [15:0] wv [6] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000,
                                16'h0080, 16'hfff4};
        logic [15:0] rv [6] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000,
                                16'h0080, 16'hf494};
        logic [9:0]  cv [6] = '{10'h200, 10'h100, 10'h380, 10'h040,
                                10'h010, 10'h3fa};
        for (int i = 0; i < 6; i++) begin
            mgmt.write_reg(PEC_ADDR_CONFIG, wv[i]);
            rd_chk(PEC_ADDR_CONFIG, rv[i]);
            ctl_chk(cv[i]);
        end
        mgmt.write_reg(PEC_ADDR_CONFIG, 16'h0000);
        rd_chk(PEC_ADDR_CONFIG, 16'h0000);
        ctl_chk(10'h000);
        line_sd = 1'b1;
        repeat (4) @(negedge clock);
        ctl_chk(10'h040);
        line_sd = 1'b0;
    endtask

    task automatic t_sm_reset;
        mgmt.write_reg(PEC_ADDR_CONFIG, 16'h041c);
        rd_chk(PEC_ADDR_CONFIG, 16'h041c);
        ctl_chk(10'h02e);
        repeat (12) @(negedge clock);
        rd_chk(PEC_ADDR_CONFIG, 16'h0414);
        ctl_chk(10'h02a);
    endtask

    task automatic t_sleep;
        raw_link = 1'b1;
        mgmt.write_reg(PEC_ADDR_CONFIG, 16'h0496);
        rd_chk(PEC_ADDR_CONFIG, 16'h0496);
        ctl_chk(10'h02f);
        mgmt.write_reg(PEC_ADDR_CONFIG, 16'h0494);
        repeat (15) @(negedge clock);
        rd_chk(PEC_ADDR_CONFIG, 16'h0494);
        ctl_chk(10'h03a);
        raw_link = 1'b0;
    endtask

    task automatic t_expansion_flags;
        an_status.partner_next_page_capable = 1'b1;
        an_status.partner_negotiation_capable = 1'b1;
        an_status.fault_event = 1'b1;
        @(negedge clock);
        an_status.fault_event = 1'b0;
        an_status.page_event = 1'b1;
        @(negedge clock);
        an_status.page_event = 1'b0;
        repeat (2) @(negedge clock);
        rd_chk(PEC_ADDR_EXPANSION, 16'h001b);
        rd_chk(PEC_ADDR_EXPANSION, 16'h0009);
        an_status.partner_next_page_capable = 1'b0;
        an_status.partner_negotiation_capable = 1'b0;
        repeat (3) @(negedge clock);
        rd_chk(PEC_ADDR_EXPANSION, 16'h0000);
    endtask

    task automatic t_refusals;
        rd_chk(5'h05, 16'h0000);
        mgmt.write_reg(PEC_ADDR_EXPANSION, 16'hffff);
        rd_chk(PEC_ADDR_EXPANSION, 16'h0000);
        mgmt.write_reg(5'h11, 16'hffff);
        rd_chk(PEC_ADDR_CONFIG, 16'h0494);
    endtask

    // ==========================================================
    // Verdict
    // ==========================================================
    task automatic tally_and_finish;
        $display("compared=%0d mismatches=%0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Whole run needs about 110 cycles; 5000 leaves wide margin
    initial begin
        #(5000 * 100);
        bad_count++;
        tally_and_finish();
    end

    initial begin
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        t_reset_values();
        t_config_bits();
        mgmt.write_reg(PEC_ADDR_CONFIG, 16'h0414);
        t_sm_reset();
        t_sleep();
        t_expansion_flags();
        t_refusals();
        tally_and_finish();
    end
endmodule

`default_nettype wire
